// file: logic/dvm_count_latch_mux.sv
// Voltmeter counter chain, transfer latches and multiplexed display drive
//
// Contract
// RULE_01 - Four and a half decade BCD counter
// RULE_02 - Divide by hundred output gated with clock
// RULE_03 - Preset low loads 30,000 next edge
// RULE_04 - Hold ten edges after wrapping to zero
// RULE_05 - Transfer copies count; display shows latches only
// RULE_06 - Only one transfer accepted per cycle
// RULE_07 - Half decade flags encode integration phase
// RULE_08 - Latched high flag drives over-range output
// RULE_09 - Thousands first bit gives under-range indication
// RULE_10 - Selected latched decade on four BCD outputs
// RULE_11 - One hot digit select outputs
// RULE_12 - Step input advances scan independently
// RULE_13 - Feedback blanks leading zeros above decade
// RULE_14 - Blank low forces digit selects low
// RULE_15 - Test pin tied high by board
// RULE_16 - Transfer arms on fall, stores on clock low
// RULE_17 - Once flag cleared only at terminal count
// RULE_18 - Scan wraps to first decade after fifth
`timescale 1ns/10ps
module dvm_count_latch_mux
  import dvm_pkg::*;
(
  input wire logic mclk,                 // System clock, 20 MHz
  input wire logic rst,                  // Asynchronous reset, active high
  input wire logic count_clock,          // Count clock pin
  input wire logic preset_n,             // Master preset, active low
  input wire logic transfer_in,          // Transfer strobe, falling edge
  input wire logic blank_n,              // Display blank, active low
  input wire logic step_in,              // Digit scan step
  input wire logic zero_blank_feedback,  // Fed back digit select
  output logic div100_out,               // One pulse per hundred counts
  output logic div2000_out,              // Thousands decade first bit
  output logic half_decade_flag_low,     // First phase flag
  output logic half_decade_flag_high,    // Second phase flag
  output logic latched_overrange_flag,   // Latched second phase flag
  output logic bcd_weight_one,           // BCD bit of weight 1
  output logic bcd_weight_two,           // BCD bit of weight 2
  output logic bcd_weight_four,          // BCD bit of weight 4
  output logic bcd_weight_eight,         // BCD bit of weight 8
  output logic digit_select_first,       // Lowest decade shown
  output logic digit_select_second,      // Second decade shown
  output logic digit_select_third,       // Third decade shown
  output logic digit_select_fourth,      // Fourth decade shown
  output logic digit_select_fifth        // Half decade shown
);

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    logic [SY_W-1:0] sy1;                // First synchroniser stage
    logic [SY_W-1:0] sy2;                // Second synchroniser stage
    logic [SY_W-1:0] prv;                // Previous synchronised level
    logic [NUM_DECADES-1:0][3:0] dig;    // Live decades
    logic [1:0] half;                    // Live half decade
    logic [3:0] pause;                   // Remaining pause edges
    logic armed;                         // Transfer armed
    logic once;                          // Transfer taken this cycle
    logic [NUM_DIGITS-1:0][3:0] lat;     // Latched digits
    logic [2:0] scan;                    // Scan position
    logic [2:0] fb_pos;                  // Decade wired to feedback
    logic div100;                        // Divide by hundred output
    logic div2000;                       // Divide by 2,000 output
    logic flag_lo;                       // Phase flag one
    logic flag_hi;                       // Phase flag two
    logic ovr;                           // Over-range output
    logic [3:0] bcd;                     // BCD outputs
    logic [NUM_DIGITS-1:0] dsel;         // Digit select outputs
  } dvm_state_s;

  dvm_state_s s_ff;                      // Registered state
  dvm_state_s nxt_s;                     // Next state

  // Edge events from synchronised inputs
  logic cc_rise;
  logic cc_fall;
  logic tr_fall;
  logic st_rise;
  logic at_top;
  logic cnt_go;                          // Count rise that advances the chain
  logic term_cnt;                        // Advance from 39,999 to 00,000

  assign cc_rise = s_ff.sy2[SY_CC] & ~s_ff.prv[SY_CC];
  assign cc_fall = ~s_ff.sy2[SY_CC] & s_ff.prv[SY_CC];
  assign tr_fall = ~s_ff.sy2[SY_TRANS] & s_ff.prv[SY_TRANS];
  assign st_rise = s_ff.sy2[SY_STEP] & ~s_ff.prv[SY_STEP];
  // Count 39,999: next edge is the terminal count
  assign at_top = (s_ff.half == PRESET_HALF) && (s_ff.dig == {NUM_DECADES{BCD_MAX}});
  // Rise that is neither a preset nor held by the pause
  assign cnt_go = cc_rise && s_ff.sy2[SY_PRESET] && (s_ff.pause == 4'h0);
  assign term_cnt = cnt_go && at_top;

  // ****************************************************
  // Leading zero test
  // ****************************************************
  // True when digit idx and all above it are zero and idx is above feedback
  function automatic logic lz_blank(input logic [NUM_DIGITS-1:0][3:0] lat,
                                    input logic [2:0] fb, input int idx);
    logic z;
    z = (idx > int'(fb));
    for (int k = 0; k < NUM_DIGITS; k++) begin
      if (k >= idx && lat[k] != 4'h0) begin
        z = 1'b0;
      end
    end
    return z;
  endfunction

  // ****************************************************
  // Next state
  // ****************************************************
  // All behaviour in one combinational process
  always_comb begin
    logic carry;
    carry = 1'b1;
    nxt_s = s_ff;
    // Two stage synchronisers plus edge history
    nxt_s.sy1 = {zero_blank_feedback, step_in, blank_n, transfer_in, preset_n, count_clock};
    nxt_s.sy2 = s_ff.sy1;
    nxt_s.prv = s_ff.sy2;
    // Counter chain on the count clock rising edge
    if (cc_rise) begin
      if (!s_ff.sy2[SY_PRESET]) begin
        nxt_s.dig = '0;                  // Load 30,000 [RULE_03]
        nxt_s.half = PRESET_HALF;
        nxt_s.pause = 4'h0;
      end else if (s_ff.pause != 4'h0) begin
        nxt_s.pause = s_ff.pause - 4'h1; // Hold at zero [RULE_04]
      end else begin
        // Ripple carry through the decades [RULE_01]
        for (int i = 0; i < NUM_DECADES; i++) begin
          if (carry) begin
            if (s_ff.dig[i] == BCD_MAX) begin
              nxt_s.dig[i] = 4'h0;
            end else begin
              nxt_s.dig[i] = s_ff.dig[i] + 4'h1;
              carry = 1'b0;
            end
          end
        end
        if (carry) begin
          nxt_s.half = s_ff.half + 2'h1;
        end
        if (at_top) begin
          nxt_s.pause = PAUSE_COUNTS;    // Start pause at 00,000 [RULE_04]
          nxt_s.once = 1'b0;             // Terminal count [RULE_17]
        end
      end
    end
    // Arm on a falling transfer unless already taken [RULE_16] [RULE_06]
    if (tr_fall && !s_ff.once) begin
      nxt_s.armed = 1'b1;
    end
    // Store when the count clock goes low [RULE_16] [RULE_05]
    if (cc_fall && s_ff.armed) begin
      for (int i = 0; i < NUM_DECADES; i++) begin
        nxt_s.lat[i] = s_ff.dig[i];
      end
      nxt_s.lat[NUM_DECADES] = {2'h0, s_ff.half};
      nxt_s.armed = 1'b0;
      nxt_s.once = 1'b1;                 // Set wins over clear [RULE_17]
    end
    // Scan counter on step, wrapping after fifth [RULE_12] [RULE_18]
    if (st_rise) begin
      nxt_s.scan = (s_ff.scan == SCAN_LAST) ? 3'h0 : s_ff.scan + 3'h1;
    end
    // Remember which decade is wired back, taken as the feedback rises [RULE_13]
    // Scan still names that decade; step period must exceed the sync lag
    if (s_ff.sy2[SY_FB] && !s_ff.prv[SY_FB]) begin
      nxt_s.fb_pos = s_ff.scan;
    end
    // Registered outputs
    nxt_s.div100 = s_ff.sy2[SY_CC] && (s_ff.dig[0] == BCD_MAX)
                   && (s_ff.dig[1] == BCD_MAX); // [RULE_02]
    nxt_s.div2000 = s_ff.dig[3][0];      // [RULE_09]
    nxt_s.flag_lo = s_ff.half[0];        // [RULE_07]
    nxt_s.flag_hi = s_ff.half[1];        // [RULE_07]
    nxt_s.ovr = s_ff.lat[NUM_DECADES][1]; // [RULE_08]
    nxt_s.bcd = s_ff.lat[s_ff.scan];     // [RULE_10]
    // One hot select, leading zero and blank gating [RULE_11] [RULE_13] [RULE_14]
    for (int i = 0; i < NUM_DIGITS; i++) begin
      nxt_s.dsel[i] = s_ff.sy2[SY_BLANK] && (s_ff.scan == 3'(i))
                      && !lz_blank(s_ff.lat, s_ff.fb_pos, i);
    end
  end

  // ****************************************************
  // State register
  // ****************************************************
  // Single register of the whole state
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
      s_ff.sy1 <= SY_RESET;
      s_ff.sy2 <= SY_RESET;
      s_ff.prv <= SY_RESET;
      s_ff.fb_pos <= FB_POS_RESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  assign div100_out = s_ff.div100;
  assign div2000_out = s_ff.div2000;
  assign half_decade_flag_low = s_ff.flag_lo;
  assign half_decade_flag_high = s_ff.flag_hi;
  assign latched_overrange_flag = s_ff.ovr;
  assign bcd_weight_one = s_ff.bcd[0];
  assign bcd_weight_two = s_ff.bcd[1];
  assign bcd_weight_four = s_ff.bcd[2];
  assign bcd_weight_eight = s_ff.bcd[3];
  assign digit_select_first = s_ff.dsel[0];
  assign digit_select_second = s_ff.dsel[1];
  assign digit_select_third = s_ff.dsel[2];
  assign digit_select_fourth = s_ff.dsel[3];
  assign digit_select_fifth = s_ff.dsel[4];

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  preset_load_a: assert property (cc_rise && !s_ff.sy2[SY_PRESET] |=> // [RULE_03]
      s_ff.half == PRESET_HALF && s_ff.dig == '0)
    else $error("preset did not load 30,000");
  pause_hold_a: assert property (cc_rise && s_ff.sy2[SY_PRESET] && s_ff.pause != 4'h0 |=> // [RULE_04]
      $stable(s_ff.dig) && $stable(s_ff.half) && s_ff.pause == $past(s_ff.pause) - 4'h1)
    else $error("count moved during pause");
  wrap_pause_a: assert property (cc_rise && s_ff.sy2[SY_PRESET] && s_ff.pause == 4'h0 // [RULE_17]
      && at_top |=> s_ff.dig == '0 && s_ff.half == 2'h0 && s_ff.pause == PAUSE_COUNTS
      && !s_ff.once)
    else $error("terminal count handling wrong");
  latch_only_a: assert property (!(cc_fall && s_ff.armed) |=> $stable(s_ff.lat)) // [RULE_05]
    else $error("latches changed without transfer");
  once_block_a: assert property (s_ff.once |-> !s_ff.armed) // [RULE_06]
    else $error("transfer armed after one taken");
  blank_sel_a: assert property (!s_ff.sy2[SY_BLANK] |=> s_ff.dsel == '0) // [RULE_14]
    else $error("digit select active while blanked");
  sel_onehot_a: assert property ($onehot0(s_ff.dsel) // [RULE_11]
      && (s_ff.dsel == '0 || s_ff.dsel[$past(s_ff.scan)]))
    else $error("digit select not one hot on scan");
  scan_wrap_a: assert property (st_rise && s_ff.scan == SCAN_LAST |=> s_ff.scan == 3'h0) // [RULE_18]
    else $error("scan did not wrap");
  bcd_mux_a: assert property (##1 s_ff.bcd == $past(s_ff.lat[s_ff.scan])) // [RULE_10]
    else $error("bcd not from latched decade");
  flag_phase_a: assert property (##1 {s_ff.flag_hi, s_ff.flag_lo} == $past(s_ff.half)) // [RULE_07]
    else $error("phase flags wrong");

  // ****************************************************
  // Counter, transfer and display checks
  // ****************************************************
  // Chain only moves on a count clock rise
  count_idle_a: assert property (!cc_rise |=> // [RULE_01]
      $stable(s_ff.dig) && $stable(s_ff.half))
    else $error("count moved without count clock");
  // Units decade steps by one, upper decades untouched
  count_inc_a: assert property (cnt_go && s_ff.dig[0] != BCD_MAX |=> // [RULE_01]
      s_ff.dig[0] == $past(s_ff.dig[0]) + 4'h1 && $stable(s_ff.half)
      && s_ff.dig[NUM_DECADES-1:1] == $past(s_ff.dig[NUM_DECADES-1:1]))
    else $error("units decade did not advance");
  // Divided clock stays low while the count clock is low
  div100_low_a: assert property (!s_ff.sy2[SY_CC] |=> !s_ff.div100) // [RULE_02]
    else $error("divided clock high while count clock low");
  // Accepted transfer sets the once flag and disarms
  once_set_a: assert property (cc_fall && s_ff.armed |=> s_ff.once && !s_ff.armed) // [RULE_17]
    else $error("accepted transfer did not set once flag");
  // Once flag survives until the terminal count
  once_keep_a: assert property (s_ff.once && !term_cnt |=> s_ff.once) // [RULE_17]
    else $error("once flag cleared before terminal count");
  // Later strobes in the same cycle are ignored
  refuse_arm_a: assert property (tr_fall && s_ff.once |=> !s_ff.armed) // [RULE_06]
    else $error("transfer armed while once flag set");
  // A falling strobe arms while no transfer is taken
  arm_fall_a: assert property (tr_fall && !s_ff.once && !cc_fall |=> s_ff.armed) // [RULE_16]
    else $error("transfer fall did not arm");
  // Latches take the live count on the storing edge
  latch_copy_a: assert property (cc_fall && s_ff.armed |=> // [RULE_05]
      s_ff.lat[NUM_DECADES-1:0] == $past(s_ff.dig)
      && s_ff.lat[NUM_DECADES] == {2'h0, $past(s_ff.half)})
    else $error("latches do not hold the count");
  // Over-range output shows the high flag at transfer
  ovr_latch_a: assert property (cc_fall && s_ff.armed |-> ##2 // [RULE_08]
      s_ff.ovr == $past(s_ff.half[1], 2))
    else $error("over-range flag not latched");
  // Under-range output low for counts below one thousand
  under_range_a: assert property (cc_fall && s_ff.armed && s_ff.half == 2'h0 // [RULE_09]
      && s_ff.dig[3] == 4'h0 |=> !s_ff.div2000)
    else $error("under-range output high below one thousand");
  // Step advances the scan by one
  scan_step_a: assert property (st_rise && s_ff.scan != SCAN_LAST |=> // [RULE_12]
      s_ff.scan == $past(s_ff.scan) + 3'h1)
    else $error("scan did not advance on step");
  // Scan stands between steps
  scan_hold_a: assert property (!st_rise |=> $stable(s_ff.scan)) // [RULE_12]
    else $error("scan moved without step");
  // A zero half decade above the fed back decade stays dark
  lead_zero_a: assert property (s_ff.scan == SCAN_LAST // [RULE_13]
      && s_ff.lat[SCAN_LAST] == 4'h0 && s_ff.fb_pos != SCAN_LAST
      |=> !s_ff.dsel[SCAN_LAST])
    else $error("leading zero in half decade not blanked");
  // Feedback rise records the decade on show
  fb_take_a: assert property (s_ff.sy2[SY_FB] && !s_ff.prv[SY_FB] |=> // [RULE_13]
      s_ff.fb_pos == $past(s_ff.scan))
    else $error("fed back decade not taken");

endmodule : dvm_count_latch_mux

// file: logic/dvm_pkg.sv
// Constants shared by the voltmeter count, latch and display logic
package dvm_pkg;
  // ****************************************************
  // Counter chain figures
  // ****************************************************
  localparam int NUM_DECADES = 4;           // Full BCD decades below the half decade
  localparam int NUM_DIGITS = 5;            // Displayed digits, half decade included
  localparam logic [3:0] BCD_MAX = 4'h9;    // Highest value of one decade
  localparam logic [1:0] PRESET_HALF = 2'h3; // Half decade after preset, count 30,000
  localparam logic [3:0] PAUSE_COUNTS = 4'ha; // Count clock edges held at zero
  // ****************************************************
  // Input synchroniser bit positions
  // ****************************************************
  localparam int SY_CC = 0;                 // Count clock
  localparam int SY_PRESET = 1;             // Preset, active low
  localparam int SY_TRANS = 2;              // Transfer strobe
  localparam int SY_BLANK = 3;              // Blank, active low
  localparam int SY_STEP = 4;               // Digit step
  localparam int SY_FB = 5;                 // Zero blank feedback
  localparam int SY_W = 6;                  // Synchroniser width
  // ****************************************************
  // Scan limit and reset values
  // ****************************************************
  localparam logic [2:0] SCAN_LAST = 3'h4;  // Last scan position before wrap
  localparam logic [2:0] FB_POS_RESET = 3'h4; // No leading blanking until fed back
  localparam logic [SY_W-1:0] SY_RESET = 6'h0e; // Idle levels: preset, transfer, blank high
endpackage : dvm_pkg

// file: tb/dvm_front_model.sv
// Front end model: count clock, master preset and transfer strobe
`timescale 1ns/10ps
module dvm_front_model (
  input wire logic mclk,         // System clock
  input wire logic div100_out,   // Divided clock from the block
  output logic count_clock,      // Count clock, low between runs
  output logic preset_n,         // Preset, pulled up when idle
  output logic transfer_in       // Comparator strobe, pulled up
);
  int hundred_hits; // Divided clock seen high late in a high phase
  // Factory test pin has no port here; the board holds it at supply
  // ****
  // Idle levels
  // ****
  initial begin
    count_clock = 1'b0;
    preset_n = 1'b1;
    transfer_in = 1'b1;
    hundred_hits = 0;
  end
  // ****
  // Count pulses, optional preset before and strobe within the high phase
  // ****
  task automatic pulse(input int n, input bit xfer, input bit pre);
    repeat (n) begin
      @(posedge mclk);
      if (pre) begin
        preset_n <= 1'b0;
        repeat (4) @(posedge mclk);
      end
      count_clock <= 1'b1;
      transfer_in <= ~xfer;
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      if (div100_out === 1'b1) hundred_hits++;
      @(posedge mclk);
      count_clock <= 1'b0;
      repeat (3) @(posedge mclk);
      transfer_in <= 1'b1;
      preset_n <= 1'b1;
    end
  endtask
endmodule // dvm_front_model

// file: tb/test_dvm_count_latch_mux.sv
// Self-checking bench for the voltmeter count, latch and display block
`timescale 1ns/10ps
module test_dvm_count_latch_mux;
  logic mclk, rst, blank_n, step_in, zero_blank_feedback, fb_en;
  logic count_clock, preset_n, transfer_in, div100_out, div2000_out;
  logic flag_lo, flag_hi, ovr; // Phase flags and latched over-range
  logic [3:0] bcd; // BCD weights 8,4,2,1
  logic [4:0] sel; // Digit selects, fifth down to first
  int bad_count = 0;
  int checks_done = 0;
  // ****
  // Design and far side
  // ****
  dvm_count_latch_mux DUT (.mclk(mclk), .rst(rst), .count_clock(count_clock),
    .preset_n(preset_n), .transfer_in(transfer_in), .blank_n(blank_n),
    .step_in(step_in), .zero_blank_feedback(zero_blank_feedback),
    .div100_out(div100_out), .div2000_out(div2000_out),
    .half_decade_flag_low(flag_lo), .half_decade_flag_high(flag_hi),
    .latched_overrange_flag(ovr), .bcd_weight_one(bcd[0]), .bcd_weight_two(bcd[1]),
    .bcd_weight_four(bcd[2]), .bcd_weight_eight(bcd[3]),
    .digit_select_first(sel[0]), .digit_select_second(sel[1]),
    .digit_select_third(sel[2]), .digit_select_fourth(sel[3]),
    .digit_select_fifth(sel[4]));
  dvm_front_model fm (.mclk(mclk), .div100_out(div100_out),
    .count_clock(count_clock), .preset_n(preset_n), .transfer_in(transfer_in));
  // Clock generator
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Board wiring of the first select back to the feedback pin
  always @(posedge mclk) zero_blank_feedback <= fb_en & sel[0];
  // ****
  // Shared tasks
  // ****
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t ns got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    if (bad_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic step;
    @(posedge mclk);
    step_in <= 1'b1;
    repeat (4) @(posedge mclk);
    step_in <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  // Walk all five positions, then confirm the wrap
  task automatic scan_chk(input logic [19:0] digs, input logic [4:0] shown);
    for (int p = 0; p < 5; p++) begin
      @(negedge mclk);
      chk({12'h0, bcd}, {12'h0, digs[p*4+:4]});
      chk({11'h0, sel}, {11'h0, shown[p] ? 5'h01 << p : 5'h00});
      step();
    end
    wait_cyc(1);
    chk({11'h0, sel}, {11'h0, shown[0] ? 5'h01 : 5'h00});
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    wait_cyc(4);
    chk({7'h0, sel, bcd}, 16'h0010);
    chk({14'h0, flag_lo, flag_hi}, 16'h0000);
  endtask
  task automatic t_once;
    fm.pulse(1, 1'b0, 1'b1);
    fm.pulse(3, 1'b0, 1'b0);
    fm.pulse(1, 1'b1, 1'b0);
    wait_cyc(6);
    chk({15'h0, div2000_out}, 16'h0000);
    chk({15'h0, ovr}, 16'h0001);
    scan_chk(20'h30004, 5'h1f);
    fm.pulse(3, 1'b1, 1'b0);
    wait_cyc(6);
    chk({12'h0, bcd}, 16'h0004);
  endtask
  task automatic t_preset_wrap;
    fm.pulse(1, 1'b0, 1'b1);
    wait_cyc(2);
    chk({14'h0, flag_lo, flag_hi}, 16'h0003);
    fm.pulse(1000, 1'b0, 1'b0);
    chk({15'h0, div2000_out}, 16'h0001);
    fm.pulse(8999, 1'b0, 1'b0);
    chk({14'h0, flag_lo, flag_hi}, 16'h0003);
    fm.pulse(1, 1'b0, 1'b0);
    chk({14'h0, flag_lo, flag_hi}, 16'h0000);
  endtask
  task automatic t_pause_blank;
    fm.pulse(10, 1'b0, 1'b0);
    fm.hundred_hits = 0;
    fm.pulse(122, 1'b0, 1'b0);
    fm.pulse(1, 1'b1, 1'b0);
    chk(16'(fm.hundred_hits), 16'h0001);
    fb_en <= 1'b1;
    wait_cyc(8);
    chk({15'h0, ovr}, 16'h0000);
    scan_chk(20'h00123, 5'h07);
  endtask
  task automatic t_blank;
    @(posedge mclk);
    blank_n <= 1'b0;
    wait_cyc(6);
    chk({11'h0, sel}, 16'h0000);
    @(posedge mclk);
    blank_n <= 1'b1;
    wait_cyc(6);
    chk({11'h0, sel}, 16'h0001);
  endtask
  // ****
  // Main sequence and watchdog
  // ****
  initial begin
    rst = 1'b1;
    blank_n = 1'b1;
    step_in = 1'b0;
    fb_en = 1'b0;
    zero_blank_feedback = 1'b0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_once();
    t_preset_wrap();
    t_pause_blank();
    t_blank();
    final_report();
  end
  initial begin
    repeat (95000) @(posedge mclk);
    bad_count++;
    final_report();
  end
endmodule // test_dvm_count_latch_mux
